/* File: sac_control.sv */
// sequencer and host port of the 12-bit plus sign sar converter
//
// Notes on behaviour
// - write fall with select low starts conversion
// - start clears sign, dac input zero
// - sign high when comparator sees negative
// - negative sign swaps input polarity during the search
// - twelve bits tested msb first
// - keep bit if input above trial
// - final test sets complete flag only
// - update latches result, resets, then eoc
// - latch loaded before interrupt asserted
// - parallel read drives 13 bits, else hi-z
// - byte mode: sign-extended high byte first
// - byte select toggles per byte-mode data read, resets
// - status bit 2 shows byte select
// - status bit 6 shows conversion busy
// - status bit 1 shows result latched
// - status bit 0 ready, cleared on access
// - interrupt low at end, cleared on read
// - interrupt cleared by starting write
// - ready output inserts read wait state
// - status write resets sequencer and status, not the latch
// - tied strobes: no interrupt, ready pulses
// - long write: latch updates, no interrupt
// - read held low: outputs stay enabled
`timescale 1ns/10ps
module sac_control
    import sac_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // host strobes, all active low
    input wire logic chip_select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic status_select_n,
    // variant select: high for byte-wide bus
    input wire logic byte_mode,
    // analog front end
    input wire logic comparator_high,
    output logic [sac_pkg::SAC_RES_BITS-1:0] dac_code,
    output logic swap_inputs,
    // data bus, two signals per pin: value and enable
    output logic [sac_pkg::SAC_DATA_BITS-1:0] data_out,
    output logic [sac_pkg::SAC_DATA_BITS-1:0] data_oe,
    // host handshake outputs
    output logic conversion_done_irq_out_n,
    output logic ready_out,
    output logic end_of_conversion
);
    import sac_pkg::*;

    // synchronised strobes
    logic cs_n_s, wr_n_s, rd_n_s, st_n_s;
    logic wr_fall, rd_fall;

    sac_edge_sync u_cs (.clock(clock), .reset(reset), .pin_n(chip_select_n), .level_n(cs_n_s), .fall());
    sac_edge_sync u_wr (.clock(clock), .reset(reset), .pin_n(write_n), .level_n(wr_n_s), .fall(wr_fall));
    sac_edge_sync u_rd (.clock(clock), .reset(reset), .pin_n(read_n), .level_n(rd_n_s), .fall(rd_fall));
    sac_edge_sync u_st (.clock(clock), .reset(reset), .pin_n(status_select_n), .level_n(st_n_s), .fall());

    // decoded host events
    logic start_ev;   // conversion start
    logic sreset_ev;  // status write reset
    logic dread_ev;   // data read leading edge
    logic sread_ev;   // status read leading edge
    logic rd_active;  // read window open

    // status write takes precedence over a start
    assign sreset_ev = wr_fall & ~cs_n_s & ~st_n_s;
    assign start_ev = wr_fall & ~cs_n_s & st_n_s;
    assign dread_ev = rd_fall & ~cs_n_s & st_n_s;
    assign sread_ev = rd_fall & ~cs_n_s & ~st_n_s;
    assign rd_active = ~cs_n_s & ~rd_n_s;

    // sequencer state
    sac_state_t state_ff, nxt_state;
    logic [15:0] tick_ff, nxt_tick;          // step timer
    logic [3:0] bit_ff, nxt_bit;             // current trial bit
    logic [11:0] sar_ff, nxt_sar;            // approximation_register
    logic sign_ff, nxt_sign;                 // sign decision
    logic conversion_complete_ff, nxt_cc;    // internal complete flag
    logic [12:0] latch_ff, nxt_latch;        // output latch
    logic eoc_ff, nxt_eoc;                   // result latched
    logic irq_ff, nxt_irq;                   // interrupt pending, active high
    logic byst_ff, nxt_byst;                 // next read is low byte
    logic wr_held_ff, nxt_wr_held;           // start strobe still low
    logic step;

    assign step = (tick_ff == 16'(SAC_BIT_CYC - 1));

    // two's complement assembly of sign and magnitude
    function automatic logic [12:0] sac_twos(input logic s, input logic [11:0] m);
        logic [12:0] w;
        w = {1'b0, m};
        sac_twos = s ? 13'(~w + 13'h0001) : w;
    endfunction : sac_twos

    // next-state for sequencer and status
    always_comb begin
        nxt_state = state_ff;
        nxt_tick = step ? 16'h0000 : 16'(tick_ff + 16'h0001);
        nxt_bit = bit_ff;
        nxt_sar = sar_ff;
        nxt_sign = sign_ff;
        nxt_cc = conversion_complete_ff;
        nxt_latch = latch_ff;
        nxt_eoc = eoc_ff;
        nxt_irq = irq_ff;
        nxt_byst = byst_ff;
        nxt_wr_held = wr_held_ff & ~wr_n_s;
        // reads clear the ready flag and interrupt
        if (dread_ev | sread_ev) begin
            nxt_irq = 1'b0;
        end
        // each byte-mode data read flips the byte pointer
        if (dread_ev & byte_mode) begin
            nxt_byst = ~byst_ff;
        end
        case (state_ff)
            SAC_IDLE: begin
                nxt_tick = 16'h0000;
            end
            SAC_SIGN: begin
                // sign test with dac at zero
                if (step) begin
                    nxt_sign = ~comparator_high;
                    nxt_bit = 4'(SAC_RES_BITS - 1);
                    nxt_sar = 12'h800;
                    nxt_state = SAC_SEARCH;
                end
            end
            SAC_SEARCH: begin
                // keep or drop trial bit, try next lower
                if (step) begin
                    nxt_sar[bit_ff] = comparator_high;
                    if (bit_ff == 4'h0) begin
                        nxt_cc = 1'b1;
                        nxt_state = SAC_DONE;
                    end else begin
                        nxt_bit = 4'(bit_ff - 4'h1);
                        nxt_sar[bit_ff - 4'h1] = 1'b1;
                    end
                end
            end
            SAC_DONE: begin
                // moves to update unconditionally; latch, eoc and interrupt untouched
                nxt_state = SAC_UPDATE;
            end
            SAC_UPDATE: begin
                // latch first, then reset internals, then notify
                nxt_latch = sac_twos(sign_ff, sar_ff);
                nxt_cc = 1'b0;
                nxt_sar = SAC_DAC_ZERO;
                nxt_sign = 1'b0;
                nxt_eoc = 1'b1;
                nxt_byst = 1'b0;
                // a still-held start strobe or an open read window suppresses the interrupt
                nxt_irq = ~wr_held_ff & ~rd_active;
                nxt_state = SAC_IDLE;
            end
            default: begin
                nxt_state = SAC_IDLE;
            end
        endcase
        // a start restarts from any state
        if (start_ev) begin
            nxt_state = SAC_SIGN;
            nxt_tick = 16'h0000;
            nxt_sign = 1'b0;
            nxt_sar = SAC_DAC_ZERO;
            nxt_cc = 1'b0;
            nxt_eoc = 1'b0;
            nxt_irq = 1'b0;
            nxt_wr_held = 1'b1;
        end
        // status write aborts and clears every status bit
        if (sreset_ev) begin
            nxt_state = SAC_IDLE;
            nxt_sign = 1'b0;
            nxt_sar = SAC_DAC_ZERO;
            nxt_cc = 1'b0;
            nxt_eoc = 1'b0;
            nxt_irq = 1'b0;
            nxt_byst = 1'b0;
            nxt_wr_held = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_ff <= SAC_IDLE;
            tick_ff <= 16'h0000;
            bit_ff <= 4'h0;
            sar_ff <= SAC_DAC_ZERO;
            sign_ff <= 1'b0;
            conversion_complete_ff <= 1'b0;
            latch_ff <= SAC_LATCH_RST;
            eoc_ff <= 1'b0;
            irq_ff <= 1'b0;
            byst_ff <= 1'b0;
            wr_held_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tick_ff <= nxt_tick;
            bit_ff <= nxt_bit;
            sar_ff <= nxt_sar;
            sign_ff <= nxt_sign;
            conversion_complete_ff <= nxt_cc;
            latch_ff <= nxt_latch;
            eoc_ff <= nxt_eoc;
            irq_ff <= nxt_irq;
            byst_ff <= nxt_byst;
            wr_held_ff <= nxt_wr_held;
        end
    end

    // output-side next values
    logic [12:0] nxt_dout, nxt_doe;
    logic [12:0] dout_ff, doe_ff;
    logic nxt_irq_n, irq_n_ff, nxt_ready, ready_ff, nxt_eoc_o, eoc_o_ff;
    logic [11:0] nxt_dac, dac_ff;
    logic nxt_swap, swap_ff;
    logic nxt_bsel, bsel_ff; // byte shown by the data read in progress
    logic busy;

    assign busy = (state_ff != SAC_IDLE);

    // bus drive, status word, handshake outputs
    always_comb begin
        nxt_dout = 13'h0000;
        nxt_doe = 13'h0000;
        nxt_bsel = bsel_ff;
        if (rd_active & ~st_n_s) begin
            // status read
            nxt_doe = 13'h00FF;
            nxt_dout[SAC_ST_SARS_POS] = busy;
            nxt_dout[SAC_ST_BYST_POS] = byst_ff;
            nxt_dout[SAC_ST_EOC_POS] = eoc_ff;
            // the read that clears the ready bit still shows it until it ends
            nxt_dout[SAC_ST_INT_POS] = sread_ev ? irq_ff : (irq_ff | dout_ff[SAC_ST_INT_POS]);
        end else if (rd_active & byte_mode) begin
            nxt_doe = 13'h00FF;
            // pointer flips at the leading edge, so keep the byte chosen there
            nxt_bsel = dread_ev ? byst_ff : bsel_ff;
            // high byte: sign copied into the top four lanes
            nxt_dout[7:0] = nxt_bsel ? latch_ff[7:0]
                : {{4{latch_ff[SAC_SIGN_POS]}}, latch_ff[11:8]};
        end else if (rd_active) begin
            nxt_doe = 13'h1FFF;
            nxt_dout = latch_ff;
        end
        nxt_irq_n = ~irq_ff;
        // wait state in the done and update steps, whether or not a read is open
        nxt_ready = ~(state_ff == SAC_UPDATE || state_ff == SAC_DONE);
        nxt_eoc_o = eoc_ff;
        nxt_dac = sar_ff;
        nxt_swap = sign_ff & (state_ff == SAC_SEARCH);
    end

    // output registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dout_ff <= 13'h0000;
            doe_ff <= 13'h0000;
            irq_n_ff <= 1'b1;
            ready_ff <= 1'b1;
            eoc_o_ff <= 1'b0;
            dac_ff <= SAC_DAC_ZERO;
            swap_ff <= 1'b0;
            bsel_ff <= 1'b0;
        end else begin
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            irq_n_ff <= nxt_irq_n;
            ready_ff <= nxt_ready;
            eoc_o_ff <= nxt_eoc_o;
            dac_ff <= nxt_dac;
            swap_ff <= nxt_swap;
            bsel_ff <= nxt_bsel;
        end
    end

    assign data_out = dout_ff;
    assign data_oe = doe_ff;
    assign conversion_done_irq_out_n = irq_n_ff;
    assign ready_out = ready_ff;
    assign end_of_conversion = eoc_o_ff;
    assign dac_code = dac_ff;
    assign swap_inputs = swap_ff;

    // sequences for the checks
    sequence s_start;
        start_ev;
    endsequence

    property p_start_clears;
        @(posedge clock) disable iff (reset) s_start |=> (sign_ff == 1'b0) && (sar_ff == 12'h000);
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear sign and dac");

    property p_start_runs;
        @(posedge clock) disable iff (reset) start_ev && !sreset_ev |=> state_ff == SAC_SIGN;
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("start did not enter sign step");

    property p_cc_then_update;
        @(posedge clock) disable iff (reset)
            $rose(conversion_complete_ff) && !start_ev && !sreset_ev |-> !eoc_ff ##1 (state_ff == SAC_UPDATE);
    endproperty
    a_cc_then_update: assert property (p_cc_then_update) else $error("complete flag not followed by update");

    property p_latch_before_irq;
        @(posedge clock) disable iff (reset)
            $rose(irq_ff) |-> $past(state_ff) == SAC_UPDATE && latch_ff == $past(nxt_latch);
    endproperty
    a_latch_before_irq: assert property (p_latch_before_irq) else $error("interrupt without latch load");

    property p_read_clears_irq;
        @(posedge clock) disable iff (reset) dread_ev && !start_ev && state_ff != SAC_UPDATE |=> !irq_ff ##1 irq_n_ff;
    endproperty
    a_read_clears_irq: assert property (p_read_clears_irq) else $error("read did not clear interrupt");

    property p_status_write;
        @(posedge clock) disable iff (reset) sreset_ev |=> state_ff == SAC_IDLE && !eoc_ff && !irq_ff && !byst_ff;
    endproperty
    a_status_write: assert property (p_status_write) else $error("status write did not reset");

    property p_byst_toggle;
        @(posedge clock) disable iff (reset)
            dread_ev && byte_mode && !sreset_ev && state_ff != SAC_UPDATE |=> byst_ff != $past(byst_ff);
    endproperty
    a_byst_toggle: assert property (p_byst_toggle) else $error("byte select did not toggle");

    property p_idle_hiz;
        @(posedge clock) disable iff (reset) !rd_active |=> data_oe == 13'h0000;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("bus driven outside read");

    property p_busy_status;
        @(posedge clock) disable iff (reset) rd_active && !st_n_s |=> data_out[6] == $past(busy);
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("busy status wrong");

    property p_held_no_irq;
        @(posedge clock) disable iff (reset)
            state_ff == SAC_UPDATE && wr_held_ff && !start_ev && !sreset_ev && !wr_n_s |=> !irq_ff && eoc_ff;
    endproperty
    a_held_no_irq: assert property (p_held_no_irq) else $error("interrupt raised under held strobe");
endmodule : sac_control

/* File: sac_pkg.sv */
// package of constants and types for the sar converter control block
package sac_pkg;
    localparam int SAC_RES_BITS = 12;             // magnitude bits
    localparam int SAC_DATA_BITS = 13;            // sign plus magnitude
    localparam int SAC_BYTE_BITS = 8;             // byte variant bus width
    localparam int SAC_SIGN_POS = 12;             // sign position in result word
    localparam int SAC_ST_SARS_POS = 6;           // status: conversion in progress
    localparam int SAC_ST_BYST_POS = 2;           // status: next byte is low byte
    localparam int SAC_ST_EOC_POS = 1;            // status: result latched
    localparam int SAC_ST_INT_POS = 0;            // status: result ready to read
    localparam int SAC_CLK_MHZ = 100;             // system clock rate
    localparam int SAC_BIT_TIME_NS = 1000;        // one bit-test period
    localparam int SAC_BIT_CYC = SAC_BIT_TIME_NS * SAC_CLK_MHZ / 1000; // cycles per step
    localparam logic [11:0] SAC_DAC_ZERO = 12'h000;  // dac start value
    localparam logic [12:0] SAC_LATCH_RST = 13'h0000; // output latch reset value
    localparam logic [7:0] SAC_CNT_W8 = 8'h00;    // unused width marker
    // sequencer states
    typedef enum logic [2:0] {
        SAC_IDLE,
        SAC_SIGN,
        SAC_SEARCH,
        SAC_DONE,
        SAC_UPDATE
    } sac_state_t;
endpackage : sac_pkg

/* File: sac_edge_sync.sv */
// two-flop synchroniser with falling-edge detect for an active-low strobe
`timescale 1ns/10ps
module sac_edge_sync (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // raw pin and results
    input wire logic pin_n,
    output logic level_n,
    output logic fall
);
    logic meta_ff; // first stage, read only by second stage
    logic sync_ff; // second stage
    logic prev_ff; // previous synced value
    logic nxt_meta, nxt_sync, nxt_prev;

    // next values
    always_comb begin
        nxt_meta = pin_n;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // registers; idle strobes are high
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign level_n = sync_ff;
    assign fall = prev_ff & ~sync_ff;
endmodule : sac_edge_sync

/* File: sac_front_model.sv */
// comparator model standing in for the analog front end
`timescale 1ns/10ps
module sac_front_model (
    // trial code and polarity swap from the block
    input wire logic [11:0] dac_code,
    input wire logic swap_inputs,
    // wanted differential input in lsb units
    input wire logic signed [13:0] vin,
    // comparator answer
    output logic comparator_high
);
    int mag; // magnitude seen after the swap
    // sign step sees dac at zero, so low means negative
    always_comb begin
        mag = swap_inputs ? -int'(vin) : int'(vin);
        comparator_high = (mag >= int'(dac_code));
    end
endmodule : sac_front_model

/* File: test_sar_adc_control_and_host_port.sv */
// self-checking bench for the sar converter control block
`timescale 1ns/10ps
module test_sar_adc_control_and_host_port;
    import sac_pkg::*;
    // clock, reset and host pins
    logic clock, reset, chip_select_n, write_n, read_n, status_select_n, byte_mode;
    // block outputs and front end
    logic comparator_high, swap_inputs, irq_n, ready_out, eoc;
    logic [11:0] dac_code;
    logic [12:0] data_out, data_oe, got, oe_seen;
    logic signed [13:0] vin; // wanted input
    int fail_count, checks_done, cycles;
    logic saw_wait; // ready went low since last clear

    sac_control sac_control_i (.clock(clock), .reset(reset), .chip_select_n(chip_select_n),
        .write_n(write_n), .read_n(read_n), .status_select_n(status_select_n),
        .byte_mode(byte_mode), .comparator_high(comparator_high), .dac_code(dac_code),
        .swap_inputs(swap_inputs), .data_out(data_out), .data_oe(data_oe),
        .conversion_done_irq_out_n(irq_n), .ready_out(ready_out), .end_of_conversion(eoc));
    sac_front_model sac_front_model_i (.dac_code(dac_code), .swap_inputs(swap_inputs),
        .vin(vin), .comparator_high(comparator_high));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // cycle ceiling well above the ~14k cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (!ready_out) saw_wait = 1'b1;
        if (cycles == 40000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("mismatches %0d, checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input logic [12:0] g, input logic [12:0] e, input string what);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask : hold

    // pins change only at the falling edge
    task automatic pins(input logic cs, input logic wr, input logic rd, input logic st);
        @(negedge clock);
        chip_select_n = cs;
        write_n = wr;
        read_n = rd;
        status_select_n = st;
    endtask : pins

    // short start pulse; returns once the start has been seen
    task automatic start(input logic signed [13:0] v);
        vin = v;
        pins(1'b0, 1'b0, 1'b1, 1'b1);
        hold(3);
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        hold(3);
    endtask : start

    // status select settles 600 ns before read falls
    task automatic rd_bus(input logic st, output logic [12:0] v);
        pins(1'b1, 1'b1, 1'b1, st);
        hold(60);
        pins(1'b0, 1'b1, 1'b0, st);
        hold(6);
        v = data_out;
        oe_seen = data_oe;
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        hold(6);
    endtask : rd_bus

    // bounded wait for end of conversion
    task automatic wait_eoc();
        int n;
        n = 0;
        while (eoc !== 1'b1 && n < 2000) begin
            hold(1);
            n++;
        end
        chk(13'(eoc), 13'h0001, "eoc wait");
    endtask : wait_eoc

    initial begin
        {chip_select_n, write_n, read_n, status_select_n} = 4'hF;
        {byte_mode, saw_wait, reset} = 3'b001;
        vin = 14'sd0;
        hold(6);
        reset = 1'b0;
        hold(5);
        chk(data_oe, 13'h0000, "idle oe");
        chk(13'(irq_n), 13'h0001, "idle irq");
        // positive input, parallel read
        start(14'sd1234);
        hold(14);
        chk(13'(dac_code), 13'h0000, "dac at start");
        chk(13'(swap_inputs), 13'h0000, "swap at start");
        rd_bus(1'b0, got);
        chk(13'(got[6]), 13'h0001, "busy bit");
        saw_wait = 1'b0;
        wait_eoc();
        chk(13'(irq_n), 13'h0000, "irq low");
        chk(13'(saw_wait), 13'h0001, "ready wait");
        rd_bus(1'b1, got);
        chk(got, 13'h04D2, "positive result");
        chk(oe_seen, 13'h1FFF, "read oe");
        chk(data_oe, 13'h0000, "oe released");
        chk(13'(irq_n), 13'h0001, "irq after read");
        // negative input, status bits
        start(-14'sd5);
        hold(300);
        chk(13'(swap_inputs), 13'h0001, "swap in search");
        wait_eoc();
        rd_bus(1'b0, got);
        chk({6'h00, got[6:0]}, 13'h0003, "status after eoc");
        rd_bus(1'b0, got);
        chk(13'(got[0]), 13'h0000, "ready bit cleared");
        rd_bus(1'b1, got);
        chk(got, 13'h1FFB, "negative result");
        // byte variant
        byte_mode = 1'b1;
        start(-14'sd5);
        wait_eoc();
        rd_bus(1'b0, got);
        chk(13'(got[2]), 13'h0000, "pointer high");
        rd_bus(1'b1, got);
        chk(13'(got[7:0]), 13'h00FF, "high byte");
        rd_bus(1'b0, got);
        chk(13'(got[2]), 13'h0001, "pointer low");
        rd_bus(1'b1, got);
        chk(13'(got[7:0]), 13'h00FB, "low byte");
        rd_bus(1'b1, got);
        chk(13'(got[7:0]), 13'h00FF, "toggle back");
        start(14'sd300);
        wait_eoc();
        rd_bus(1'b1, got);
        chk(13'(got[7:0]), 13'h0001, "pointer reset");
        byte_mode = 1'b0;
        // start clears irq, restart mid conversion
        start(14'sd7);
        wait_eoc();
        start(14'sd100);
        chk(13'(irq_n), 13'h0001, "irq by start");
        hold(400);
        start(-14'sd2047);
        wait_eoc();
        rd_bus(1'b1, got);
        chk(got, 13'h1801, "restart result");
        // status write aborts
        start(14'sd9);
        hold(200);
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        pins(1'b0, 1'b0, 1'b1, 1'b0);
        hold(3);
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        hold(1500);
        chk(13'(eoc), 13'h0000, "aborted eoc");
        rd_bus(1'b0, got);
        chk({6'h00, got[6:0]}, 13'h0000, "status cleared");
        // tied strobes held past the conversion
        vin = 14'sd77;
        saw_wait = 1'b0;
        pins(1'b0, 1'b0, 1'b0, 1'b1);
        hold(8);
        chk(data_out, 13'h1801, "previous result");
        hold(1500);
        chk(13'(eoc), 13'h0001, "long strobe eoc");
        chk(data_out, 13'h004D, "long strobe latch");
        chk(13'(irq_n), 13'h0001, "no irq");
        chk(13'(saw_wait), 13'h0001, "ready pulse");
        // read held low, write strobed
        vin = -14'sd100;
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        hold(4);
        pins(1'b0, 1'b0, 1'b0, 1'b1);
        hold(3);
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        hold(6);
        wait_eoc();
        hold(4);
        chk(data_out, 13'h1F9C, "held read data");
        chk(data_oe, 13'h1FFF, "held read oe");
        chk(13'(irq_n), 13'h0001, "held read irq");
        results();
    end
endmodule : test_sar_adc_control_and_host_port
